// ===== pg_mask_pkg.sv
// Package with offsets, reset values and field layout of the power-good tree mask registers
package pg_mask_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_OUT2_REGULATOR_PG_MASK = 8'ha8;
  localparam logic [7:0] OFS_OUT2_PIN_RAIL_PG_MASK = 8'ha9;
  localparam logic [7:0] OFS_OUT3_REGULATOR_PG_MASK = 8'haa;
  localparam logic [7:0] OFS_OUT3_PIN_RAIL_PG_MASK = 8'hab;
  localparam logic [7:0] RST_OUT2_REGULATOR_PG_MASK = 8'hc0;
  localparam logic [7:0] RST_OUT2_PIN_RAIL_PG_MASK = 8'h2f;
  localparam logic [7:0] RST_OUT3_REGULATOR_PG_MASK = 8'h00;
  localparam logic [7:0] RST_OUT3_PIN_RAIL_PG_MASK = 8'h00;
  // Regulator mask field positions
  localparam int BIT_LDO_A2_A = 7;
  localparam int BIT_SWITCH_A1 = 6;
  localparam int BIT_BUCK_SIX = 5;
  localparam int BIT_BUCK_ONE = 0;
  // Pin and rail mask field positions
  localparam int BIT_CONTROL_PIN_FIVE = 7;
  localparam int BIT_CONTROL_PIN_FOUR = 6;
  localparam int BIT_CONTROL_PIN_TWO = 5;
  localparam int BIT_CONTROL_PIN_ONE = 4;
  localparam int BIT_TERMINATION_LDO = 3;
  localparam int BIT_SWITCH_B2 = 2;
  localparam int BIT_SWITCH_B1 = 1;
  localparam int BIT_LDO_A3_B = 0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage

// ===== pg_tree.sv
// One power-good tree: masked AND of sixteen sources, registered
`timescale 1ns/1ps
`default_nettype none
module pg_tree
  import pg_mask_pkg::*;
(
  input wire logic clk, // Register clock
  input wire logic reset, // Asynchronous reset, high
  input wire logic ce, // Clock enable
  input wire logic [7:0] reg_good, // Regulator power-good inputs
  input wire logic [7:0] pin_good, // Control pin and rail inputs
  input wire logic [7:0] reg_mask, // 1 excludes a regulator
  input wire logic [7:0] pin_mask, // 1 excludes a pin or rail
  output logic good // Tree result
);
  typedef struct packed {
    logic good;
  } tree_state_t;
  tree_state_t st;
  tree_state_t next_st;

  // A masked bit is forced good so it cannot pull the tree low
  always_comb begin
    next_st = st;
    next_st.good = &(reg_good | reg_mask) & &(pin_good | pin_mask);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign good = st.good;

  property p_tree_and;
    @(posedge clk) disable iff (reset)
      (ce && !reset)
        |=> good == (&($past(reg_good) | $past(reg_mask)) & &($past(pin_good) | $past(pin_mask)));
  endproperty
  a_tree_and: assert property (p_tree_and) else $error("Tree result wrong");
endmodule
`default_nettype wire

// ===== power_good_tree_mask_regs.sv
// Mask register bank and power-good trees for the second and third outputs
`timescale 1ns/1ps
`default_nettype none
module power_good_tree_mask_regs
  import pg_mask_pkg::*;
(
  input wire logic CLK, // 40 MHz register clock
  input wire logic RESET, // Asynchronous reset, high
  input wire logic CE, // Clock enable, low freezes state
  input wire logic WR_EN, // Register write strobe
  input wire logic RD_EN, // Register read strobe
  input wire logic [ADDR_W-1:0] ADDR, // Register offset
  input wire logic [DATA_W-1:0] WDATA, // Write data
  input wire logic [7:0] REG_GOOD, // ldo_a2_a, switch_a1, buck_six..buck_one
  input wire logic [7:0] PIN_GOOD, // pins five, four, two, one, rails
  output logic [DATA_W-1:0] RDATA, // Registered read data
  output logic RVALID, // Read data valid pulse
  output logic SECOND_OUTPUT_PG, // Second output tree result
  output logic THIRD_OUTPUT_PG // Third output tree result
);
  typedef struct packed {
    logic [7:0] out2_regulator_pg_mask;
    logic [7:0] out2_pin_rail_pg_mask;
    logic [7:0] out3_regulator_pg_mask;
    logic [7:0] out3_pin_rail_pg_mask;
    logic [7:0] rdata;
    logic rvalid;
  } regs_state_t;
  regs_state_t st;
  regs_state_t next_st;

  // Shared decode of an offset into read data
  function automatic logic [7:0] read_mux(input regs_state_t s, input logic [7:0] a);
    case (a)
      OFS_OUT2_REGULATOR_PG_MASK: read_mux = s.out2_regulator_pg_mask;
      OFS_OUT2_PIN_RAIL_PG_MASK: read_mux = s.out2_pin_rail_pg_mask;
      OFS_OUT3_REGULATOR_PG_MASK: read_mux = s.out3_regulator_pg_mask;
      OFS_OUT3_PIN_RAIL_PG_MASK: read_mux = s.out3_pin_rail_pg_mask;
      default: read_mux = READ_UNMAPPED;
    endcase
  endfunction

  // Writes land next edge; reads return old contents, so a same-cycle write is not seen
  always_comb begin
    next_st = st;
    next_st.rvalid = RD_EN;
    if (RD_EN) begin
      next_st.rdata = read_mux(st, ADDR);
    end
    if (WR_EN) begin
      case (ADDR)
        OFS_OUT2_REGULATOR_PG_MASK: next_st.out2_regulator_pg_mask = WDATA;
        OFS_OUT2_PIN_RAIL_PG_MASK: next_st.out2_pin_rail_pg_mask = WDATA;
        OFS_OUT3_REGULATOR_PG_MASK: next_st.out3_regulator_pg_mask = WDATA;
        OFS_OUT3_PIN_RAIL_PG_MASK: next_st.out3_pin_rail_pg_mask = WDATA;
        default: ;
      endcase
    end
  end

  // Reset values per register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st.out2_regulator_pg_mask <= RST_OUT2_REGULATOR_PG_MASK;
      st.out2_pin_rail_pg_mask <= RST_OUT2_PIN_RAIL_PG_MASK;
      st.out3_regulator_pg_mask <= RST_OUT3_REGULATOR_PG_MASK;
      st.out3_pin_rail_pg_mask <= RST_OUT3_PIN_RAIL_PG_MASK;
      st.rdata <= 8'h00;
      st.rvalid <= 1'b0;
    end else if (CE) begin
      st <= next_st;
    end
  end

  assign RDATA = st.rdata;
  assign RVALID = st.rvalid;

  // Trees take one cycle; masks are already registered so the path is short
  // second tree
  pg_tree u_tree2 (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .reg_good(REG_GOOD),
    .pin_good(PIN_GOOD),
    .reg_mask(st.out2_regulator_pg_mask),
    .pin_mask(st.out2_pin_rail_pg_mask),
    .good(SECOND_OUTPUT_PG)
  );

  pg_tree u_tree3 (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .reg_good(REG_GOOD),
    .pin_good(PIN_GOOD),
    .reg_mask(st.out3_regulator_pg_mask),
    .pin_mask(st.out3_pin_rail_pg_mask),
    .good(THIRD_OUTPUT_PG)
  );

  property p_wr_out2_reg;
    @(posedge CLK) disable iff (RESET)
      (CE && WR_EN && ADDR == OFS_OUT2_REGULATOR_PG_MASK)
        |=> st.out2_regulator_pg_mask == $past(WDATA);
  endproperty
  a_wr_out2_reg: assert property (p_wr_out2_reg) else $error("A8 write lost");

  property p_rd_out2_reg;
    @(posedge CLK) disable iff (RESET)
      (CE && RD_EN && ADDR == OFS_OUT2_REGULATOR_PG_MASK && !WR_EN)
        |=> RVALID && RDATA == st.out2_regulator_pg_mask;
  endproperty
  a_rd_out2_reg: assert property (p_rd_out2_reg) else $error("A8 readback wrong");

  property p_rst_out2_reg;
    @(posedge CLK) $fell(RESET) |-> st.out2_regulator_pg_mask == RST_OUT2_REGULATOR_PG_MASK;
  endproperty
  a_rst_out2_reg: assert property (p_rst_out2_reg) else $error("A8 reset value wrong");

  property p_wr_out2_pin;
    @(posedge CLK) disable iff (RESET)
      (CE && WR_EN && ADDR == OFS_OUT2_PIN_RAIL_PG_MASK)
        |=> st.out2_pin_rail_pg_mask == $past(WDATA);
  endproperty
  a_wr_out2_pin: assert property (p_wr_out2_pin) else $error("A9 write lost");

  property p_rst_out2_pin;
    @(posedge CLK) $fell(RESET) |-> st.out2_pin_rail_pg_mask == RST_OUT2_PIN_RAIL_PG_MASK;
  endproperty
  a_rst_out2_pin: assert property (p_rst_out2_pin) else $error("A9 reset value wrong");

  property p_wr_out3_reg;
    @(posedge CLK) disable iff (RESET)
      (CE && WR_EN && ADDR == OFS_OUT3_REGULATOR_PG_MASK)
        |=> st.out3_regulator_pg_mask == $past(WDATA);
  endproperty
  a_wr_out3_reg: assert property (p_wr_out3_reg) else $error("AA write lost");

  property p_wr_out3_pin;
    @(posedge CLK) disable iff (RESET)
      (CE && WR_EN && ADDR == OFS_OUT3_PIN_RAIL_PG_MASK)
        |=> st.out3_pin_rail_pg_mask == $past(WDATA);
  endproperty
  a_wr_out3_pin: assert property (p_wr_out3_pin) else $error("AB write lost");

  property p_rst_out3;
    @(posedge CLK) $fell(RESET) |-> (st.out3_regulator_pg_mask == RST_OUT3_REGULATOR_PG_MASK)
      && (st.out3_pin_rail_pg_mask == RST_OUT3_PIN_RAIL_PG_MASK);
  endproperty
  a_rst_out3: assert property (p_rst_out3) else $error("AA/AB reset value wrong");

  property p_tree2;
    @(posedge CLK) disable iff (RESET)
      (CE && !RESET && &(REG_GOOD | st.out2_regulator_pg_mask)
        && &(PIN_GOOD | st.out2_pin_rail_pg_mask)) |=> SECOND_OUTPUT_PG;
  endproperty
  a_tree2: assert property (p_tree2) else $error("Second tree not good");

  property p_tree3_low;
    @(posedge CLK) disable iff (RESET)
      (CE && !RESET && |(~REG_GOOD & ~st.out3_regulator_pg_mask)) |=> !THIRD_OUTPUT_PG;
  endproperty
  a_tree3_low: assert property (p_tree3_low) else $error("Third tree good, source bad");

  // Readback returns the contents held before the read, even with a write alongside
  property p_rd_out2_pin;
    @(posedge CLK) disable iff (RESET)
      (CE && RD_EN && ADDR == OFS_OUT2_PIN_RAIL_PG_MASK)
        |=> RVALID && RDATA == $past(st.out2_pin_rail_pg_mask);
  endproperty
  a_rd_out2_pin: assert property (p_rd_out2_pin) else $error("A9 readback wrong");

  property p_rd_out3_reg;
    @(posedge CLK) disable iff (RESET)
      (CE && RD_EN && ADDR == OFS_OUT3_REGULATOR_PG_MASK)
        |=> RVALID && RDATA == $past(st.out3_regulator_pg_mask);
  endproperty
  a_rd_out3_reg: assert property (p_rd_out3_reg) else $error("AA readback wrong");

  property p_rd_out3_pin;
    @(posedge CLK) disable iff (RESET)
      (CE && RD_EN && ADDR == OFS_OUT3_PIN_RAIL_PG_MASK)
        |=> RVALID && RDATA == $past(st.out3_pin_rail_pg_mask);
  endproperty
  a_rd_out3_pin: assert property (p_rd_out3_pin) else $error("AB readback wrong");

  // A mask moves only on a write to its own offset, so unmapped writes cannot alias it
  property p_hold_out2_reg;
    @(posedge CLK) disable iff (RESET)
      !(CE && WR_EN && ADDR == OFS_OUT2_REGULATOR_PG_MASK)
        |=> $stable(st.out2_regulator_pg_mask);
  endproperty
  a_hold_out2_reg: assert property (p_hold_out2_reg) else $error("A8 moved unwritten");

  property p_hold_out2_pin;
    @(posedge CLK) disable iff (RESET)
      !(CE && WR_EN && ADDR == OFS_OUT2_PIN_RAIL_PG_MASK)
        |=> $stable(st.out2_pin_rail_pg_mask);
  endproperty
  a_hold_out2_pin: assert property (p_hold_out2_pin) else $error("A9 moved unwritten");

  property p_hold_out3_reg;
    @(posedge CLK) disable iff (RESET)
      !(CE && WR_EN && ADDR == OFS_OUT3_REGULATOR_PG_MASK)
        |=> $stable(st.out3_regulator_pg_mask);
  endproperty
  a_hold_out3_reg: assert property (p_hold_out3_reg) else $error("AA moved unwritten");

  property p_hold_out3_pin;
    @(posedge CLK) disable iff (RESET)
      !(CE && WR_EN && ADDR == OFS_OUT3_PIN_RAIL_PG_MASK)
        |=> $stable(st.out3_pin_rail_pg_mask);
  endproperty
  a_hold_out3_pin: assert property (p_hold_out3_pin) else $error("AB moved unwritten");

  // Second tree drops on any unmasked bad source; third rises when all unmasked are good
  property p_tree2_low;
    @(posedge CLK) disable iff (RESET)
      (CE && !RESET && (|(~REG_GOOD & ~st.out2_regulator_pg_mask)
        || |(~PIN_GOOD & ~st.out2_pin_rail_pg_mask))) |=> !SECOND_OUTPUT_PG;
  endproperty
  a_tree2_low: assert property (p_tree2_low) else $error("Second tree good, source bad");

  property p_tree3;
    @(posedge CLK) disable iff (RESET)
      (CE && !RESET && &(REG_GOOD | st.out3_regulator_pg_mask)
        && &(PIN_GOOD | st.out3_pin_rail_pg_mask)) |=> THIRD_OUTPUT_PG;
  endproperty
  a_tree3: assert property (p_tree3) else $error("Third tree not good");
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench for the power-good tree mask register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pg_mask_pkg::*;
;
  logic CLK, RESET, CE, WR_EN, RD_EN;
  logic [7:0] ADDR, WDATA, REG_GOOD, PIN_GOOD, RDATA;
  logic RVALID, SECOND_OUTPUT_PG, THIRD_OUTPUT_PG;
  logic [7:0] m [4]; // Shadow masks a8..ab, kept from writes
  logic [7:0] pat [4] = '{8'h81, 8'h7e, 8'h3c, 8'hc3};
  int miscompares = 0;
  int check_count = 0;

  power_good_tree_mask_regs dut (.CLK(CLK), .RESET(RESET), .CE(CE), .WR_EN(WR_EN),
    .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA), .REG_GOOD(REG_GOOD), .PIN_GOOD(PIN_GOOD),
    .RDATA(RDATA), .RVALID(RVALID), .SECOND_OUTPUT_PG(SECOND_OUTPUT_PG),
    .THIRD_OUTPUT_PG(THIRD_OUTPUT_PG));

  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One write strobe; WR_EN drops after the taking edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR_EN <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR_EN <= 1'b0;
  endtask

  // Read strobe, then a bounded wait for the one-cycle valid pulse
  task rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(posedge CLK);
    RD_EN <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD_EN <= 1'b0;
    n = 0;
    #1;
    while (RVALID !== 1'b1 && n < 4) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (n != 0) begin
      miscompares++;
      end_of_test();
    end else begin
      check(RDATA, exp);
    end
  endtask

  // Drop one source at a time; an excluded source must not pull a tree low
  task sweep;
    logic [15:0] g;
    for (int i = 0; i < 17; i++) begin
      g = 16'hffff;
      if (i < 16) g[i] = 1'b0;
      @(posedge CLK);
      REG_GOOD <= g[15:8];
      PIN_GOOD <= g[7:0];
      repeat (2) @(posedge CLK);
      #1;
      check({7'h00, SECOND_OUTPUT_PG}, {7'h00, &(g | {m[0], m[1]})});
      check({7'h00, THIRD_OUTPUT_PG}, {7'h00, &(g | {m[2], m[3]})});
    end
  endtask

  initial begin
    RESET = 1'b1;
    CE = 1'b1;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR = 8'h00;
    WDATA = 8'h00;
    REG_GOOD = 8'h00;
    PIN_GOOD = 8'h00;
    m = '{8'hc0, 8'h2f, 8'h00, 8'h00};
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    // Reset values, plus an unmapped offset reading zero
    rd(8'ha8, 8'hc0);
    rd(8'ha9, 8'h2f);
    rd(8'haa, 8'h00);
    rd(8'hab, 8'h00);
    rd(8'hac, READ_UNMAPPED);
    sweep();
    // Fresh patterns 81, 7e, 3c, c3 into a8..ab, plus a write to unmapped ac, then read back
    for (int k = 0; k < 4; k++) begin
      wr(8'ha8 + 8'(k), pat[k]);
      m[k] = pat[k];
    end
    wr(8'hac, 8'hff);
    for (int k = 0; k < 4; k++) rd(8'ha8 + 8'(k), m[k]);
    sweep();
    // A write while the clock enable is low is lost; enable drops on an edge
    @(posedge CLK);
    CE <= 1'b0;
    wr(8'ha8, 8'h00);
    CE <= 1'b1;
    rd(8'ha8, m[0]);
    // A second reset mid-run must bring the written masks back to reset values
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    m = '{8'hc0, 8'h2f, 8'h00, 8'h00};
    for (int k = 0; k < 4; k++) rd(8'ha8 + 8'(k), m[k]);
    sweep();
    end_of_test();
  end
endmodule
`default_nettype wire
